// ---- verilog/rrpa_core.sv ----
`timescale 1ns/1ns
`include "rrpa_cfg.svh"

module rrpa_core #(
    parameter int MS_CYCLES = `RRPA_MS_NS / `RRPA_CLK_NS,
    parameter int EV_DEPTH = 16,
    parameter int NSET = 16,
    parameter logic [NSET*16-1:0] SET_MIN = '0,
    parameter logic [NSET*16-1:0] SET_MAX = {NSET{16'h270f}},
    parameter logic [NSET*16-1:0] SET_DEF = '0
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire rrpa_pkg::rrpa_req_t req,
    output rrpa_pkg::rrpa_rsp_t rsp,
    input wire logic ev_valid,
    input wire logic [1:0] ev_channel,
    input wire logic [3:0] ev_code,
    input wire logic loc_wr,
    input wire logic [3:0] loc_index,
    input wire logic [15:0] loc_data,
    output logic loc_ack,
    output logic loc_refused,
    input wire logic [3:0] set_rd_index,
    output logic [15:0] set_rd_data,
    input wire rrpa_pkg::rrpa_fault_t fault_pin,
    input wire logic auto_reset_pin,
    output logic settings_bank_select,
    output logic [7:0] overcurrent_event_mask,
    output logic [7:0] earth_fault_event_mask,
    output logic [9:0] output_signal_event_mask,
    output logic [7:0] link_node_address,
    output logic link_rate,
    output logic supervision_out,
    output logic internal_fault_led,
    output logic format_pulse,
    output logic access_open
);

    localparam int EVW = $clog2(EV_DEPTH);
    logic [9:0] pw_r;
    logic open_r, sv_test_r, fault_hit_r, ms_tick;
    logic [15:0] time_r, d;
    logic [31:0] ms_cnt_r;
    logic stat_auto_r, stat_ovf_r;
    logic [7:0] fault_code_r, fault_code_nxt;
    logic [3:0] confirm_r;
    rrpa_pkg::rrpa_fault_t fault_s1_r, fault_s2_r;
    logic auto_s1_r, auto_s2_r;
    logic [15:0] set_r [NSET];
    rrpa_pkg::rrpa_event_t ev_mem [EV_DEPTH];
    logic [EVW-1:0] ev_wr_r, ev_rd_r;
    logic [EVW:0] ev_cnt_r;
    rrpa_pkg::rrpa_event_t ev_last_r;
    logic ev_enabled, ev_push, ev_pop, ev_full;
    logic wr, rd, do_format, rset_ok, lset_ok;

    // Remote request decode helpers
    assign wr = req.valid && req.write;
    assign rd = req.valid && !req.write;
    assign d = req.data;
    assign do_format = wr && req.param == rrpa_pkg::P_FORMAT && open_r
        && d == `RRPA_FORMAT_CMD;
    assign rset_ok = wr && req.param == rrpa_pkg::P_SETTING && open_r
        && d >= SET_MIN[req.index*16 +: 16] && d <= SET_MAX[req.index*16 +: 16];
    assign lset_ok = loc_wr && loc_data >= SET_MIN[loc_index*16 +: 16]
        && loc_data <= SET_MAX[loc_index*16 +: 16];

    // Pins from the self-test hardware are asynchronous
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fault_s1_r <= '0;
            fault_s2_r <= '0;
            auto_s1_r <= 1'b0;
            auto_s2_r <= 1'b0;
        end else begin
            fault_s1_r <= fault_pin;
            fault_s2_r <= fault_s1_r;
            auto_s1_r <= auto_reset_pin;
            auto_s2_r <= auto_s1_r;
        end
    end

    // Millisecond enable from the system clock
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ms_cnt_r <= '0;
        end else if (ms_cnt_r == 32'(MS_CYCLES - 1)) begin
            ms_cnt_r <= '0;
        end else begin
            ms_cnt_r <= ms_cnt_r + 32'd1;
        end
    end
    assign ms_tick = ms_cnt_r == 32'(MS_CYCLES - 1);

    // Seconds counter in ms; a remote set wins over the tick
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            time_r <= '0;
        end else if (wr && req.param == rrpa_pkg::P_TIME) begin
            if (d <= `RRPA_TIME_WRAP) begin
                time_r <= d;
            end
        end else if (ms_tick) begin
            time_r <= (time_r == `RRPA_TIME_WRAP) ? 16'h0000 : time_r + 16'h0001;
        end
    end

    // Fault code priority: worst memory faults first
    always_comb begin
        fault_code_nxt = `RRPA_FC_NONE;
        if (fault_s2_r.rom) begin
            fault_code_nxt = `RRPA_FC_ROM;
        end else if (fault_s2_r.ram) begin
            fault_code_nxt = `RRPA_FC_RAM;
        end else if (fault_s2_r.ee_key) begin
            fault_code_nxt = `RRPA_FC_EEKEY;
        end else if (fault_s2_r.ee_blk1 && fault_s2_r.ee_blk2 && fault_s2_r.ee_diff) begin
            fault_code_nxt = `RRPA_FC_EEDIFF;
        end else if (fault_s2_r.ee_blk1 && fault_s2_r.ee_blk2) begin
            fault_code_nxt = `RRPA_FC_EE12;
        end else if (fault_s2_r.ee_blk2) begin
            fault_code_nxt = `RRPA_FC_EE2;
        end else if (fault_s2_r.ee_blk1) begin
            fault_code_nxt = `RRPA_FC_EE1;
        end else if (fault_s2_r.trip_path) begin
            fault_code_nxt = `RRPA_FC_TRIP;
        end else if (fault_s2_r.ref_low[0]) begin
            fault_code_nxt = `RRPA_FC_LO1;
        end else if (fault_s2_r.ref_low[1]) begin
            fault_code_nxt = `RRPA_FC_LO5;
        end else if (fault_s2_r.ref_low[2]) begin
            fault_code_nxt = `RRPA_FC_LO25;
        end else if (fault_s2_r.ref_high[0]) begin
            fault_code_nxt = `RRPA_FC_HI1;
        end else if (fault_s2_r.ref_high[1]) begin
            fault_code_nxt = `RRPA_FC_HI5;
        end else if (fault_s2_r.ref_high[2]) begin
            fault_code_nxt = `RRPA_FC_HI25;
        end else if (fault_s2_r.filter) begin
            fault_code_nxt = `RRPA_FC_FILT;
        end else if (fault_s2_r.adc_stall) begin
            fault_code_nxt = `RRPA_FC_ADC;
        end
    end

    // A fault must persist before it counts as permanent; then it latches
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            confirm_r <= '0;
            fault_hit_r <= 1'b0;
            fault_code_r <= `RRPA_FC_NONE;
        end else if (!fault_hit_r) begin
            if (fault_code_nxt == `RRPA_FC_NONE) begin
                confirm_r <= '0;
            end else if (ms_tick) begin
                if (confirm_r == 4'(`RRPA_FAULT_CONFIRM_MS - 1)) begin
                    fault_hit_r <= 1'b1;
                    fault_code_r <= fault_code_nxt;
                end else begin
                    confirm_r <= confirm_r + 4'd1;
                end
            end
        end
    end

    // Supervision output and fault LED, by test or by fault
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sv_test_r <= 1'b0;
            supervision_out <= 1'b0;
            internal_fault_led <= 1'b0;
        end else begin
            if (wr && req.param == rrpa_pkg::P_SV_TEST && d <= 16'h0001) begin
                sv_test_r <= d[0];
            end
            supervision_out <= sv_test_r || fault_hit_r;
            internal_fault_led <= sv_test_r || fault_hit_r;
        end
    end

    // Password: open on a match, change or close only while open
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pw_r <= `RRPA_PW_RST;
            open_r <= 1'b0;
        end else if (do_format) begin
            pw_r <= `RRPA_PW_RST;
            open_r <= 1'b0;
        end else if (wr && req.param == rrpa_pkg::P_PW_OPEN) begin
            if (d >= `RRPA_PW_MIN && d <= `RRPA_PW_MAX && d[9:0] == pw_r) begin
                open_r <= 1'b1;
            end
        end else if (wr && req.param == rrpa_pkg::P_PW_CHANGE && open_r
            && d <= `RRPA_PW_MAX) begin
            if (d == 16'h0000) begin
                open_r <= 1'b0;
            end else begin
                pw_r <= d[9:0];
            end
        end
    end
    assign access_open = open_r;

    // Plain configuration parameters; format restores factory values
    always_ff @(posedge clk_sys) begin
        if (rst || do_format) begin
            settings_bank_select <= 1'b0;
            overcurrent_event_mask <= `RRPA_OC_MASK_RST;
            earth_fault_event_mask <= `RRPA_EF_MASK_RST;
            output_signal_event_mask <= `RRPA_OUT_MASK_RST;
            link_node_address <= `RRPA_ADDR_RST;
            link_rate <= `RRPA_RATE_RST;
        end else if (wr) begin
            if (req.param == rrpa_pkg::P_BANK && d <= 16'h0001) begin
                settings_bank_select <= d[0];
            end
            if (req.param == rrpa_pkg::P_MASK_OC && d <= 16'h00ff) begin
                overcurrent_event_mask <= d[7:0];
            end
            if (req.param == rrpa_pkg::P_MASK_EF && d <= 16'h00ff) begin
                earth_fault_event_mask <= d[7:0];
            end
            if (req.param == rrpa_pkg::P_MASK_OUT && d <= 16'h03ff) begin
                output_signal_event_mask <= d[9:0];
            end
            if (req.param == rrpa_pkg::P_LINK_ADDR && d >= `RRPA_ADDR_MIN
                && d <= `RRPA_ADDR_MAX) begin
                link_node_address <= d[7:0];
            end
            if (req.param == rrpa_pkg::P_LINK_RATE
                && (d == `RRPA_RATE_W_LO || d == `RRPA_RATE_W_HI)) begin
                link_rate <= d == `RRPA_RATE_W_HI;
            end
        end
    end

    // Setting table; remote write wins a same-cycle clash on one entry
    for (genvar i = 0; i < NSET; i++) begin : g_set
        always_ff @(posedge clk_sys) begin
            if (rst || do_format) begin
                set_r[i] <= SET_DEF[i*16 +: 16];
            end else if (rset_ok && req.index == 4'(i)) begin
                set_r[i] <= d;
            end else if (lset_ok && loc_index == 4'(i)
                && !(rset_ok && req.index == loc_index)) begin
                set_r[i] <= loc_data;
            end
        end
    end

    // Local write answer and setting read port
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            loc_ack <= 1'b0;
            loc_refused <= 1'b0;
            set_rd_data <= '0;
        end else begin
            loc_ack <= loc_wr;
            loc_refused <= loc_wr && !(lset_ok && !(rset_ok && req.index == loc_index));
            set_rd_data <= set_r[set_rd_index];
        end
    end

    // Event filter by channel mask
    always_comb begin
        ev_enabled = 1'b0;
        case (ev_channel)
            2'b00: ev_enabled = ev_code < 4'(`RRPA_OC_BITS)
                && overcurrent_event_mask[ev_code[2:0]];
            2'b01: ev_enabled = ev_code < 4'(`RRPA_EF_BITS)
                && earth_fault_event_mask[ev_code[2:0]];
            2'b10: ev_enabled = ev_code <= 4'd9 && output_signal_event_mask[ev_code];
            default: ev_enabled = 1'b0;
        endcase
    end
    assign ev_full = ev_cnt_r == (EVW+1)'(EV_DEPTH);
    assign ev_pop = rd && req.param == rrpa_pkg::P_EV_READ && ev_cnt_r != '0;
    assign ev_push = ev_valid && ev_enabled && (!ev_full || ev_pop);

    // Event register: oldest first, each entry leaves once
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ev_wr_r <= '0;
            ev_rd_r <= '0;
            ev_cnt_r <= '0;
            ev_last_r <= '0;
        end else begin
            if (ev_push) begin
                ev_mem[ev_wr_r] <= '{stamp: time_r, channel: ev_channel, code: ev_code};
                ev_wr_r <= (ev_wr_r == EVW'(EV_DEPTH - 1)) ? '0 : ev_wr_r + 1'b1;
            end
            if (ev_pop) begin
                ev_last_r <= ev_mem[ev_rd_r];
                ev_rd_r <= (ev_rd_r == EVW'(EV_DEPTH - 1)) ? '0 : ev_rd_r + 1'b1;
            end
            ev_cnt_r <= ev_cnt_r + (EVW+1)'(ev_push) - (EVW+1)'(ev_pop);
        end
    end

    // Status flags; a new condition beats a same-cycle clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stat_auto_r <= 1'b0;
            stat_ovf_r <= 1'b0;
        end else begin
            if (wr && req.param == rrpa_pkg::P_STATUS && d == 16'h0000) begin
                stat_auto_r <= 1'b0;
                stat_ovf_r <= 1'b0;
            end
            if (auto_s2_r) begin
                stat_auto_r <= 1'b1;
            end
            if (ev_valid && ev_enabled && ev_full && !ev_pop) begin
                stat_ovf_r <= 1'b1;
            end
        end
    end

    // One answer per request, the cycle after it is taken
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rsp <= '0;
            format_pulse <= 1'b0;
        end else begin
            format_pulse <= do_format;
            rsp <= '0;
            rsp.valid <= req.valid;
            if (rd) begin
                case (req.param)
                    rrpa_pkg::P_BANK: rsp.data <= {15'h0000, settings_bank_select};
                    rrpa_pkg::P_MASK_OC: rsp.data <= {8'h00, overcurrent_event_mask};
                    rrpa_pkg::P_MASK_EF: rsp.data <= {8'h00, earth_fault_event_mask};
                    rrpa_pkg::P_MASK_OUT: rsp.data <= {6'h00, output_signal_event_mask};
                    rrpa_pkg::P_FAULT_CODE: rsp.data <= {8'h00, fault_code_r};
                    rrpa_pkg::P_LINK_ADDR: rsp.data <= {8'h00, link_node_address};
                    rrpa_pkg::P_LINK_RATE: begin
                        rsp.data <= link_rate ? `RRPA_RATE_R_HI : `RRPA_RATE_R_LO;
                    end
                    rrpa_pkg::P_EV_READ: begin
                        rsp.empty <= ev_cnt_r == '0;
                        rsp.event_data <= ev_pop ? ev_mem[ev_rd_r] : '0;
                    end
                    rrpa_pkg::P_EV_REREAD: rsp.event_data <= ev_last_r;
                    rrpa_pkg::P_STATUS: rsp.data <= {14'h0, stat_ovf_r, stat_auto_r};
                    rrpa_pkg::P_TIME: rsp.data <= time_r;
                    rrpa_pkg::P_SETTING: rsp.data <= set_r[req.index];
                    default: rsp.refused <= 1'b1;
                endcase
            end else if (wr) begin
                case (req.param)
                    rrpa_pkg::P_BANK: rsp.refused <= d > 16'h0001;
                    rrpa_pkg::P_MASK_OC, rrpa_pkg::P_MASK_EF: rsp.refused <= d > 16'h00ff;
                    rrpa_pkg::P_MASK_OUT: rsp.refused <= d > 16'h03ff;
                    rrpa_pkg::P_PW_OPEN: begin
                        rsp.refused <= !(d >= `RRPA_PW_MIN && d <= `RRPA_PW_MAX
                            && d[9:0] == pw_r);
                    end
                    rrpa_pkg::P_PW_CHANGE: rsp.refused <= !open_r || d > `RRPA_PW_MAX;
                    rrpa_pkg::P_SV_TEST: rsp.refused <= d > 16'h0001;
                    rrpa_pkg::P_FORMAT: rsp.refused <= !do_format;
                    rrpa_pkg::P_LINK_ADDR: begin
                        rsp.refused <= d < `RRPA_ADDR_MIN || d > `RRPA_ADDR_MAX;
                    end
                    rrpa_pkg::P_LINK_RATE: begin
                        rsp.refused <= !(d == `RRPA_RATE_W_LO || d == `RRPA_RATE_W_HI);
                    end
                    rrpa_pkg::P_STATUS: rsp.refused <= d != 16'h0000;
                    rrpa_pkg::P_TIME: rsp.refused <= d > `RRPA_TIME_WRAP;
                    rrpa_pkg::P_SETTING: rsp.refused <= !rset_ok;
                    default: rsp.refused <= 1'b1;
                endcase
            end
        end
    end
endmodule

// ---- shared/rrpa_cfg.svh ----
`ifndef RRPA_CFG_SVH
`define RRPA_CFG_SVH

// Timing: clock period and the unit time of the seconds counter
`define RRPA_CLK_NS 4
`define RRPA_MS_NS 1000000
`define RRPA_FAULT_CONFIRM_MS 2
`define RRPA_TIME_WRAP 16'hea5f

// Accepted write ranges and read-back rate codes
`define RRPA_PW_MIN 16'h0001
`define RRPA_PW_MAX 16'h03e7
`define RRPA_ADDR_MIN 16'h0001
`define RRPA_ADDR_MAX 16'h00fe
`define RRPA_RATE_W_LO 16'h0030
`define RRPA_RATE_W_HI 16'h0060
`define RRPA_RATE_R_LO 16'h12c0
`define RRPA_RATE_R_HI 16'h2580
`define RRPA_FORMAT_CMD 16'h0002

// Reset and factory values
`define RRPA_PW_RST 10'h001
`define RRPA_ADDR_RST 8'h01
`define RRPA_RATE_RST 1'b1
`define RRPA_OC_MASK_RST 8'hff
`define RRPA_EF_MASK_RST 8'hff
`define RRPA_OUT_MASK_RST 10'h3ff

// Event mask widths of the overcurrent and earth fault channels
`define RRPA_OC_BITS 8
`define RRPA_EF_BITS 8

// Internal fault codes
`define RRPA_FC_NONE 8'h00
`define RRPA_FC_TRIP 8'h04
`define RRPA_FC_ROM 8'h1e
`define RRPA_FC_RAM 8'h32
`define RRPA_FC_EE1 8'h33
`define RRPA_FC_EE2 8'h34
`define RRPA_FC_EE12 8'h35
`define RRPA_FC_EEDIFF 8'h36
`define RRPA_FC_EEKEY 8'h38
`define RRPA_FC_LO1 8'hc3
`define RRPA_FC_LO5 8'h83
`define RRPA_FC_LO25 8'h43
`define RRPA_FC_HI1 8'hcb
`define RRPA_FC_HI5 8'h8b
`define RRPA_FC_HI25 8'h4b
`define RRPA_FC_FILT 8'hfc
`define RRPA_FC_ADC 8'hfd

`endif

// ---- shared/rrpa_pkg.sv ----
package rrpa_pkg;

    // Parameter selected by a remote request
    typedef enum logic [3:0] {
        P_BANK = 4'b0000,
        P_MASK_OC = 4'b0001,
        P_MASK_EF = 4'b0010,
        P_MASK_OUT = 4'b0011,
        P_PW_OPEN = 4'b0100,
        P_PW_CHANGE = 4'b0101,
        P_SV_TEST = 4'b0110,
        P_FORMAT = 4'b0111,
        P_FAULT_CODE = 4'b1000,
        P_LINK_ADDR = 4'b1001,
        P_LINK_RATE = 4'b1010,
        P_EV_READ = 4'b1011,
        P_EV_REREAD = 4'b1100,
        P_STATUS = 4'b1101,
        P_TIME = 4'b1110,
        P_SETTING = 4'b1111
    } rrpa_param_t;

    typedef struct packed {
        logic valid;
        logic write;
        rrpa_param_t param;
        logic [3:0] index;
        logic [15:0] data;
    } rrpa_req_t;

    typedef struct packed {
        logic [15:0] stamp;
        logic [1:0] channel;
        logic [3:0] code;
    } rrpa_event_t;

    typedef struct packed {
        logic valid;
        logic refused;
        logic empty;
        logic [15:0] data;
        rrpa_event_t event_data;
    } rrpa_rsp_t;

    // Self-test findings, one flag per fault type
    typedef struct packed {
        logic trip_path;
        logic rom;
        logic ram;
        logic ee_blk1;
        logic ee_blk2;
        logic ee_diff;
        logic ee_key;
        logic [2:0] ref_low;
        logic [2:0] ref_high;
        logic filter;
        logic adc_stall;
    } rrpa_fault_t;

endpackage

// ---- testbench/rrpa_core_properties.sv ----
`timescale 1ns/1ns
module rrpa_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire rrpa_pkg::rrpa_req_t req,
    input wire rrpa_pkg::rrpa_rsp_t rsp,
    input wire logic [7:0] link_node_address,
    input wire logic [7:0] overcurrent_event_mask,
    input wire logic supervision_out,
    input wire logic internal_fault_led,
    input wire logic format_pulse,
    input wire logic access_open
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Request decodes; a fresh open may still be in flight on the flag
    wire logic wr = req.valid && req.write;
    wire logic pwo = wr && req.param == rrpa_pkg::P_PW_OPEN;
    property p_answer; req.valid |=> rsp.valid; endproperty
    a_answer: assert property (p_answer) else $error("request got no answer");
    property p_open; $rose(access_open) |-> $past(pwo) || $past(pwo, 2); endproperty
    a_open: assert property (p_open) else $error("access opened by itself");
    property p_chg; wr && req.param == rrpa_pkg::P_PW_CHANGE && !access_open
        && !$past(pwo) |=> rsp.refused; endproperty
    a_chg: assert property (p_chg) else $error("closed change accepted");
    property p_set; wr && req.param == rrpa_pkg::P_SETTING && !access_open
        && !$past(pwo) |=> rsp.refused; endproperty
    a_set: assert property (p_set) else $error("closed setting write taken");
    property p_sv; wr && req.param == rrpa_pkg::P_SV_TEST && req.data == 16'h0001
        |-> ##[2:3] (supervision_out && internal_fault_led); endproperty
    a_sv: assert property (p_sv) else $error("test output not driven");
    property p_fmt; format_pulse |-> ##[0:2]
        (overcurrent_event_mask == 8'hff && link_node_address == 8'h01); endproperty
    a_fmt: assert property (p_fmt) else $error("format kept old values");
    property p_addr; link_node_address != 8'h00 && link_node_address != 8'hff; endproperty
    a_addr: assert property (p_addr) else $error("node address out of range");
    property p_keep; wr && req.param == rrpa_pkg::P_LINK_ADDR && (req.data == 16'h0000
        || req.data > 16'h00fe) |=> rsp.refused && $stable(link_node_address); endproperty
    a_keep: assert property (p_keep) else $error("bad address stored");
    c_empty: cover property (rsp.valid && rsp.empty);
    c_fmt: cover property (format_pulse);
    c_sv: cover property ($rose(supervision_out));
endmodule
bind rrpa_core rrpa_chk i_chk (.clk_sys(clk_sys), .rst(rst), .req(req), .rsp(rsp),
    .link_node_address(link_node_address), .overcurrent_event_mask(overcurrent_event_mask),
    .supervision_out(supervision_out), .internal_fault_led(internal_fault_led),
    .format_pulse(format_pulse), .access_open(access_open));

// ---- testbench/rrpa_comm_model.sv ----
`timescale 1ns/1ns
module rrpa_comm_model (
    input wire logic clk_sys,
    output rrpa_pkg::rrpa_req_t req,
    input wire rrpa_pkg::rrpa_rsp_t rsp
);
    initial req = '0;
    // One poll per call, held across the taking edge; any parameter, read or write
    task automatic xfer(input logic wr, input rrpa_pkg::rrpa_param_t p,
        input logic [3:0] i, input logic [15:0] d, output rrpa_pkg::rrpa_rsp_t r);
        @(negedge clk_sys);
        req <= '{valid: 1'b1, write: wr, param: p, index: i, data: d};
        @(negedge clk_sys);
        r = rsp;
        req <= '0;
    endtask
endmodule

// ---- testbench/relay_remote_parameter_access_tb_top.sv ----
`timescale 1ns/1ns
module relay_remote_parameter_access_tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    rrpa_pkg::rrpa_req_t req;
    rrpa_pkg::rrpa_rsp_t rsp;
    rrpa_pkg::rrpa_rsp_t r;
    rrpa_pkg::rrpa_fault_t fault_pin = '0;
    logic ev_valid = 1'b0;
    logic [1:0] ev_channel = 2'h0;
    logic [3:0] ev_code = 4'h0;
    logic auto_reset_pin = 1'b0;
    logic loc_wr = 1'b0;
    logic [15:0] loc_data = 16'h0000;
    logic [15:0] set_rd;
    logic loc_ack, loc_ref;
    logic bank, rate, sv_out, led, acc;
    logic [7:0] oc, ef, addr;
    logic [9:0] om;
    int num_errors = 0;
    int n_compared = 0;
    // Short tick count keeps fault confirmation within a few dozen cycles
    rrpa_core #(.MS_CYCLES(10)) i_dut (.clk_sys(clk_sys), .rst(rst), .req(req), .rsp(rsp),
        .ev_valid(ev_valid), .ev_channel(ev_channel), .ev_code(ev_code), .loc_wr(loc_wr),
        .loc_index(4'h3), .loc_data(loc_data), .loc_ack(loc_ack), .loc_refused(loc_ref),
        .set_rd_index(4'h3), .set_rd_data(set_rd), .fault_pin(fault_pin),
        .auto_reset_pin(auto_reset_pin), .settings_bank_select(bank),
        .overcurrent_event_mask(oc), .earth_fault_event_mask(ef),
        .output_signal_event_mask(om), .link_node_address(addr), .link_rate(rate),
        .supervision_out(sv_out), .internal_fault_led(led), .format_pulse(), .access_open(acc));
    rrpa_comm_model i_comm (.clk_sys(clk_sys), .req(req), .rsp(rsp));
    initial forever #2 clk_sys = ~clk_sys;
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("compared=%0d errors=%0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Extra cycle lets one-cycle-late flags settle before they are looked at
    task automatic op(input logic w, input rrpa_pkg::rrpa_param_t p, input logic [15:0] d,
        input logic [3:0] i = 4'h0);
        i_comm.xfer(w, p, i, d, r);
        @(negedge clk_sys);
    endtask
    task automatic ev(input logic [1:0] c, input logic [3:0] k);
        ev_valid = 1'b1;
        ev_channel = c;
        ev_code = k;
        @(negedge clk_sys);
        ev_valid = 1'b0;
        @(negedge clk_sys);
    endtask
    // Local write on setting 3; answer flags stand one cycle only
    task automatic loc(input logic [15:0] v, input logic bad);
        loc_data = v;
        loc_wr = 1'b1;
        @(negedge clk_sys);
        loc_wr = 1'b0;
        chk({loc_ack, loc_ref}, {1'b1, bad});
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic do_rst;
        rst = 1'b1;
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
    endtask
    task automatic t_access;
        chk({bank, oc, ef, om, addr, rate, acc}, {1'b0, 8'hff, 8'hff, 10'h3ff, 8'h01, 2'b10});
        op(1, rrpa_pkg::P_SETTING, 16'h0064, 4'h3);
        chk(r.refused, 1);
        op(1, rrpa_pkg::P_PW_CHANGE, 16'h0005);
        chk(r.refused, 1);
        op(1, rrpa_pkg::P_PW_OPEN, 16'h0002);
        chk({r.refused, acc}, 2'b10);
        op(1, rrpa_pkg::P_PW_OPEN, 16'h0001);
        chk({r.refused, acc}, 2'b01);
        op(1, rrpa_pkg::P_SETTING, 16'h0064, 4'h3);
        op(1, rrpa_pkg::P_SETTING, 16'h2710, 4'h3);
        chk(r.refused, 1);
        op(0, rrpa_pkg::P_SETTING, 16'h0000, 4'h3);
        chk(r.data, 16'h0064);
        op(1, rrpa_pkg::P_PW_CHANGE, 16'h0000);
        chk(acc, 0);
        loc(16'h2710, 1);
        chk(set_rd, 16'h0064);
        loc(16'h0032, 0);
        chk(set_rd, 16'h0032);
    endtask
    task automatic t_regs;
        op(1, rrpa_pkg::P_BANK, 16'h0001);
        op(1, rrpa_pkg::P_BANK, 16'h0002);
        chk({r.refused, bank}, 2'b11);
        op(1, rrpa_pkg::P_MASK_OC, 16'h000f);
        op(1, rrpa_pkg::P_MASK_OUT, 16'h0155);
        op(1, rrpa_pkg::P_MASK_EF, 16'h0100);
        chk({r.refused, oc, ef, om}, {1'b1, 8'h0f, 8'hff, 10'h155});
        op(1, rrpa_pkg::P_LINK_ADDR, 16'h0000);
        op(1, rrpa_pkg::P_LINK_ADDR, 16'h00fe);
        op(1, rrpa_pkg::P_LINK_RATE, 16'h0030);
        op(0, rrpa_pkg::P_LINK_RATE, 16'h0000);
        chk({addr, rate, r.data}, {8'hfe, 1'b0, 16'h12c0});
        op(0, rrpa_pkg::P_PW_OPEN, 16'h0000);
        chk(r.refused, 1);
        op(0, rrpa_pkg::P_FAULT_CODE, 16'h0000);
        chk(r.data, 16'h0000);
        op(1, rrpa_pkg::P_TIME, 16'hea60);
        chk(r.refused, 1);
        op(1, rrpa_pkg::P_TIME, 16'hea5f);
        repeat (12) @(negedge clk_sys);
        op(0, rrpa_pkg::P_TIME, 16'h0000);
        chk(r.data <= 16'h0001, 1);
    endtask
    // Code 5 is masked off, code 2 passes; then drained, re-read twice
    task automatic t_events;
        ev(2'h0, 4'h5);
        ev(2'h0, 4'h2);
        op(0, rrpa_pkg::P_EV_READ, 16'h0000);
        chk({r.empty, r.event_data.channel, r.event_data.code}, 7'h02);
        op(0, rrpa_pkg::P_EV_READ, 16'h0000);
        chk(r.empty, 1);
        repeat (2) op(0, rrpa_pkg::P_EV_REREAD, 16'h0000);
        chk(r.event_data.code, 4'h2);
        repeat (17) ev(2'h1, 4'h1);
        op(0, rrpa_pkg::P_STATUS, 16'h0000);
        chk(r.data, 16'h0002);
        auto_reset_pin = 1'b1;
        repeat (4) @(negedge clk_sys);
        auto_reset_pin = 1'b0;
        op(0, rrpa_pkg::P_STATUS, 16'h0000);
        chk(r.data, 16'h0003);
        op(1, rrpa_pkg::P_STATUS, 16'h0000);
        op(0, rrpa_pkg::P_STATUS, 16'h0000);
        chk(r.data, 16'h0000);
    endtask
    task automatic t_test_format;
        op(1, rrpa_pkg::P_SV_TEST, 16'h0001);
        @(negedge clk_sys);
        chk({sv_out, led}, 2'b11);
        op(1, rrpa_pkg::P_SV_TEST, 16'h0000);
        @(negedge clk_sys);
        chk({sv_out, led}, 2'b00);
        op(1, rrpa_pkg::P_PW_OPEN, 16'h0001);
        op(1, rrpa_pkg::P_FORMAT, 16'h0001);
        chk(r.refused, 1);
        op(1, rrpa_pkg::P_FORMAT, 16'h0002);
        @(negedge clk_sys);
        chk({oc, bank, addr, rate, acc}, {8'hff, 1'b0, 8'h01, 2'b10});
        do_rst();
    endtask
    // Each latched fault needs its own reset to clear
    task automatic t_faults;
        logic [7:0] fc [5] = '{8'h38, 8'h83, 8'h4b, 8'hfd, 8'h1e};
        int n;
        for (int i = 0; i < 5; i++) begin
            fault_pin = '0;
            case (i)
                0: fault_pin.ee_key = 1'b1;
                1: fault_pin.ref_low[1] = 1'b1;
                2: fault_pin.ref_high[2] = 1'b1;
                3: fault_pin.adc_stall = 1'b1;
                default: fault_pin.rom = 1'b1;
            endcase
            fault_pin.trip_path = (i == 4);
            for (n = 0; n < 200 && sv_out !== 1'b1; n++) begin
                @(negedge clk_sys);
            end
            if (n == 200) begin
                num_errors++;
                print_verdict();
            end
            op(0, rrpa_pkg::P_FAULT_CODE, 16'h0000);
            chk({led, r.data}, {9'h100, fc[i]});
            fault_pin = '0;
            do_rst();
        end
    endtask
    initial begin
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
        t_access();
        t_regs();
        t_events();
        t_test_format();
        t_faults();
        print_verdict();
    end
endmodule
